// ### shared/picp_pkg.sv
package picp_pkg;

	// Register offsets
	localparam logic [4:0] OFS_PRIORITY_LEVELS_A      = 5'h00;
	localparam logic [4:0] OFS_PRIORITY_LEVELS_B      = 5'h01;
	localparam logic [4:0] OFS_PRIORITY_LEVELS_C      = 5'h02;
	localparam logic [4:0] OFS_PRIORITY_LEVELS_D      = 5'h03;
	localparam logic [4:0] OFS_PRIORITY_LEVELS_E      = 5'h04;
	localparam logic [4:0] OFS_VECTOR_TABLE_BASE      = 5'h05;
	localparam logic [4:0] OFS_FAST_MATCH_SLOT0       = 5'h06;
	localparam logic [4:0] OFS_FAST_VECTOR_LOW_SLOT0  = 5'h07;
	localparam logic [4:0] OFS_FAST_VECTOR_HIGH_SLOT0 = 5'h08;
	localparam logic [4:0] OFS_FAST_MATCH_SLOT1       = 5'h09;
	localparam logic [4:0] OFS_FAST_VECTOR_LOW_SLOT1  = 5'h0A;
	localparam logic [4:0] OFS_FAST_VECTOR_HIGH_SLOT1 = 5'h0B;
	localparam logic [4:0] OFS_REQUEST_PENDING_A      = 5'h0C;
	localparam logic [4:0] OFS_REQUEST_PENDING_B      = 5'h0D;
	localparam logic [4:0] OFS_REQUEST_PENDING_C      = 5'h0E;
	localparam logic [4:0] OFS_CONTROLLER_CONTROL     = 5'h12;

	// Writable bits; the rest read as zero
	localparam logic [15:0] MASK_LEVELS_A = 16'hC3FF;
	localparam logic [15:0] MASK_LEVELS_B = 16'hFCFF;
	localparam logic [15:0] MASK_LEVELS_C = 16'hF3FF;
	localparam logic [15:0] MASK_LEVELS_D = 16'hFFF0;
	localparam logic [15:0] MASK_LEVELS_E = 16'h00FF;
	localparam logic [15:0] MASK_VBASE    = 16'h3FFF;
	localparam logic [15:0] MASK_FMATCH   = 16'h007F;
	localparam logic [15:0] MASK_FVHIGH   = 16'h001F;

	// Reset values
	localparam logic [15:0] RST_REG      = 16'h0000;
	localparam logic [20:0] RST_PROG_ADDR = 21'h000000;

	// Control register status field positions
	localparam int CTL_DUE_BIT   = 15;
	localparam int CTL_FAST_BIT  = 14;
	localparam int CTL_LVL_LSB   = 12;
	localparam int CTL_VEC_LSB   = 5;
	localparam int CTL_WAKE_BIT  = 4;

	// Source numbering
	localparam int NUM_LEVELS = 4;
	localparam int NUM_FIXED  = 16;
	localparam int NUM_CFG    = 30;
	localparam int NUM_DEBUG_FIELDS = 5;
	localparam logic [1:0] FIXED_LEVEL = 2'h3;
	localparam logic [1:0] FAST_LEVEL  = 2'h2;

	// Field index (two-bit pair, registers a..e packed low to high) per configurable source
	localparam int SRC_FIELD [NUM_CFG] = '{
		4, 3, 2, 1, 0, 7,
		15, 14, 13, 11, 10, 9, 8,
		23, 22, 20, 19, 18, 17, 16,
		31, 30, 29, 28, 27, 26,
		35, 34, 33, 32
	};

endpackage : picp_pkg

// ### verilog/picp_prio_enc.sv
`timescale 1ns/1ps
module picp_prio_enc #(
	parameter int N  = 46,
	parameter int IW = 7
) (
	// Requests
	input  wire logic [N-1:0]  req,
	// Result
	output      logic          hit,
	output      logic [IW-1:0] idx
);

	// Lowest index wins
	always_comb begin
		hit = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				hit = 1'b1;
				idx = IW'(i);
			end
		end
	end

endmodule : picp_prio_enc

// ### verilog/picp_interrupt_arbiter.sv
`timescale 1ns/1ps
// Summary of operation
// - 46 sources, four levels; only the 30 configurable ones can be disabled
// - Fixed-priority sources ignore level fields
// - Lowest source number wins within level
// - Flag due request and give service address
// - Normal vector is base joined to number
// - Core mask bits gate lower levels
// - Level 2 match uses fast vector address
// - Fast flagged early; core checks instruction
// - Pending request wakes clocks in low power
// - Wake only sources enabled before entry
// - Reset drives initial program address
// - Sixteen registers at module offsets
// - Peripheral field: off, level 0..2
// - Debug field: off, level 1..3
// - Register a field layout
// - Register b field layout
// - Reserved bits read zero, ignore writes
// - Base gives upper 14, source lower 7
module picp_interrupt_arbiter
	import picp_pkg::*;
#(
	parameter int NSRC = 46,
	parameter int VW   = 7,
	parameter int AW   = 21
) (
	// Clock and reset
	input  wire logic            mclk,
	input  wire logic            srst,
	// Register port
	input  wire logic [4:0]      reg_addr,
	input  wire logic [15:0]     reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	output      logic [15:0]     reg_rdata_ff,
	// Interrupt sources
	input  wire logic [NSRC-1:0] irq_req,
	// Core side
	input  wire logic [1:0]      core_status_mask,
	input  wire logic            low_power_mode,
	output      logic            irq_due_ff,
	output      logic            irq_fast_ff,
	output      logic [1:0]      irq_level_ff,
	output      logic [VW-1:0]   irq_vector_ff,
	output      logic [AW-1:0]   vector_address_bus_ff,
	// System integration unit
	output      logic            wake_request_ff
);

	// Register file
	logic [15:0]     levels_ff [5];
	logic [15:0]     nxt_levels [5];
	logic [15:0]     vbase_ff, nxt_vbase;
	logic [15:0]     fmatch_ff [2];
	logic [15:0]     nxt_fmatch [2];
	logic [15:0]     fvlow_ff [2];
	logic [15:0]     nxt_fvlow [2];
	logic [15:0]     fvhigh_ff [2];
	logic [15:0]     nxt_fvhigh [2];
	logic [15:0]     nxt_rdata;

	// Arbitration
	logic [NSRC-1:0] src_en;
	logic [1:0]      src_lvl [NSRC];
	logic [NSRC-1:0] lvl_req [NUM_LEVELS];
	logic            lvl_hit [NUM_LEVELS];
	logic [VW-1:0]   lvl_idx [NUM_LEVELS];
	logic            win_hit;
	logic [1:0]      win_lvl;
	logic [VW-1:0]   win_idx;
	logic            win_fast;
	logic [AW-1:0]   win_addr;
	logic            nxt_due, nxt_fast;
	logic [1:0]      nxt_level;
	logic [VW-1:0]   nxt_vector;
	logic [AW-1:0]   nxt_vab;

	// Low-power wake
	logic            lp_seen_ff, nxt_lp_seen;
	logic [NSRC-1:0] wake_en_ff, nxt_wake_en;
	logic            nxt_wake;

	// Level field decode: returns {enabled, level}
	function automatic logic [2:0] field_decode(input logic [1:0] fld, input logic dbg);
		logic [2:0] r;
		r = 3'h0;
		if (fld != 2'h0) begin
			if (dbg)
				r = {1'b1, fld};
			else
				r = {1'b1, 2'(fld - 2'h1)};
		end
		return r;
	endfunction : field_decode

	function automatic logic [1:0] field_of(input logic [79:0] flat, input int pos);
		return flat[2*pos +: 2];
	endfunction : field_of

	function automatic logic [15:0] reg_merge(input logic [15:0] wd, input logic [15:0] msk);
		return wd & msk;
	endfunction : reg_merge

	// Register writes
	always_comb begin
		for (int i = 0; i < 5; i++)
			nxt_levels[i] = levels_ff[i];
		nxt_vbase = vbase_ff;
		for (int s = 0; s < 2; s++) begin
			nxt_fmatch[s] = fmatch_ff[s];
			nxt_fvlow[s]  = fvlow_ff[s];
			nxt_fvhigh[s] = fvhigh_ff[s];
		end
		if (reg_wr) begin
			case (reg_addr)
				OFS_PRIORITY_LEVELS_A: begin
					nxt_levels[0] = reg_merge(reg_wdata, MASK_LEVELS_A);
				end
				OFS_PRIORITY_LEVELS_B: begin
					nxt_levels[1] = reg_merge(reg_wdata, MASK_LEVELS_B);
				end
				OFS_PRIORITY_LEVELS_C: begin
					nxt_levels[2] = reg_merge(reg_wdata, MASK_LEVELS_C);
				end
				OFS_PRIORITY_LEVELS_D: begin
					nxt_levels[3] = reg_merge(reg_wdata, MASK_LEVELS_D);
				end
				OFS_PRIORITY_LEVELS_E: begin
					nxt_levels[4] = reg_merge(reg_wdata, MASK_LEVELS_E);
				end
				OFS_VECTOR_TABLE_BASE: begin
					nxt_vbase = reg_merge(reg_wdata, MASK_VBASE);
				end
				OFS_FAST_MATCH_SLOT0: begin
					nxt_fmatch[0] = reg_merge(reg_wdata, MASK_FMATCH);
				end
				OFS_FAST_VECTOR_LOW_SLOT0: begin
					nxt_fvlow[0] = reg_wdata;
				end
				OFS_FAST_VECTOR_HIGH_SLOT0: begin
					nxt_fvhigh[0] = reg_merge(reg_wdata, MASK_FVHIGH);
				end
				OFS_FAST_MATCH_SLOT1: begin
					nxt_fmatch[1] = reg_merge(reg_wdata, MASK_FMATCH);
				end
				OFS_FAST_VECTOR_LOW_SLOT1: begin
					nxt_fvlow[1] = reg_wdata;
				end
				OFS_FAST_VECTOR_HIGH_SLOT1: begin
					nxt_fvhigh[1] = reg_merge(reg_wdata, MASK_FVHIGH);
				end
				default: begin
				end
			endcase
		end
	end

	// Register reads; unmapped offsets read zero
	always_comb begin
		nxt_rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				OFS_PRIORITY_LEVELS_A:      nxt_rdata = levels_ff[0];
				OFS_PRIORITY_LEVELS_B:      nxt_rdata = levels_ff[1];
				OFS_PRIORITY_LEVELS_C:      nxt_rdata = levels_ff[2];
				OFS_PRIORITY_LEVELS_D:      nxt_rdata = levels_ff[3];
				OFS_PRIORITY_LEVELS_E:      nxt_rdata = levels_ff[4];
				OFS_VECTOR_TABLE_BASE:      nxt_rdata = vbase_ff;
				OFS_FAST_MATCH_SLOT0:       nxt_rdata = fmatch_ff[0];
				OFS_FAST_VECTOR_LOW_SLOT0:  nxt_rdata = fvlow_ff[0];
				OFS_FAST_VECTOR_HIGH_SLOT0: nxt_rdata = fvhigh_ff[0];
				OFS_FAST_MATCH_SLOT1:       nxt_rdata = fmatch_ff[1];
				OFS_FAST_VECTOR_LOW_SLOT1:  nxt_rdata = fvlow_ff[1];
				OFS_FAST_VECTOR_HIGH_SLOT1: nxt_rdata = fvhigh_ff[1];
				OFS_REQUEST_PENDING_A:      nxt_rdata = irq_req[15:0];
				OFS_REQUEST_PENDING_B:      nxt_rdata = irq_req[31:16];
				OFS_REQUEST_PENDING_C:      nxt_rdata = 16'(irq_req[NSRC-1:32]);
				OFS_CONTROLLER_CONTROL: begin
					nxt_rdata[CTL_DUE_BIT]                 = irq_due_ff;
					nxt_rdata[CTL_FAST_BIT]                = irq_fast_ff;
					nxt_rdata[CTL_LVL_LSB +: 2]            = irq_level_ff;
					nxt_rdata[CTL_VEC_LSB +: VW]           = irq_vector_ff;
					nxt_rdata[CTL_WAKE_BIT]                = wake_request_ff;
				end
				default:                    nxt_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int i = 0; i < 5; i++)
				levels_ff[i] <= RST_REG;
			vbase_ff <= RST_REG;
			for (int s = 0; s < 2; s++) begin
				fmatch_ff[s] <= RST_REG;
				fvlow_ff[s]  <= RST_REG;
				fvhigh_ff[s] <= RST_REG;
			end
			reg_rdata_ff <= RST_REG;
		end else begin
			levels_ff    <= nxt_levels;
			vbase_ff     <= nxt_vbase;
			fmatch_ff    <= nxt_fmatch;
			fvlow_ff     <= nxt_fvlow;
			fvhigh_ff    <= nxt_fvhigh;
			reg_rdata_ff <= nxt_rdata;
		end
	end

	// Per-source enable and level
	always_comb begin
		logic [79:0] flat;
		logic [2:0]  dec;
		flat = {levels_ff[4], levels_ff[3], levels_ff[2], levels_ff[1], levels_ff[0]};
		dec  = 3'h0;
		for (int s = 0; s < NUM_FIXED; s++) begin
			src_en[s]  = 1'b1;
			src_lvl[s] = FIXED_LEVEL;
		end
		for (int c = 0; c < NSRC - NUM_FIXED; c++) begin
			dec = field_decode(field_of(flat, SRC_FIELD[c]),
				SRC_FIELD[c] < NUM_DEBUG_FIELDS);
			src_en[c + NUM_FIXED]  = dec[2];
			src_lvl[c + NUM_FIXED] = dec[1:0];
		end
	end

	// Split requests by level, masked by the core (levels at or above mask pass)
	always_comb begin
		for (int l = 0; l < NUM_LEVELS; l++) begin
			for (int s = 0; s < NSRC; s++) begin
				lvl_req[l][s] = irq_req[s] && src_en[s] && (src_lvl[s] == 2'(l))
					&& (2'(l) >= core_status_mask);
			end
		end
	end

	for (genvar g = 0; g < NUM_LEVELS; g++) begin : g_level
		picp_prio_enc #(
			.N  (NSRC),
			.IW (VW)
		) u_enc (
			.req (lvl_req[g]),
			.hit (lvl_hit[g]),
			.idx (lvl_idx[g])
		);
	end

	// Winner: highest level first, then address selection
	always_comb begin
		win_hit = 1'b0;
		win_lvl = 2'h0;
		win_idx = '0;
		for (int l = 0; l < NUM_LEVELS; l++) begin
			if (lvl_hit[l]) begin
				win_hit = 1'b1;
				win_lvl = 2'(l);
				win_idx = lvl_idx[l];
			end
		end
		win_fast = 1'b0;
		win_addr = {vbase_ff[13:0], win_idx};
		if (win_lvl == FAST_LEVEL) begin
			if (win_idx == fmatch_ff[0][VW-1:0]) begin
				win_fast = 1'b1;
				win_addr = {fvhigh_ff[0][4:0], fvlow_ff[0]};
			end else if (win_idx == fmatch_ff[1][VW-1:0]) begin
				win_fast = 1'b1;
				win_addr = {fvhigh_ff[1][4:0], fvlow_ff[1]};
			end
		end
	end

	// Core outputs hold the last address while nothing is due
	always_comb begin
		nxt_due    = win_hit;
		nxt_fast   = win_hit && win_fast;
		nxt_level  = irq_level_ff;
		nxt_vector = irq_vector_ff;
		nxt_vab    = vector_address_bus_ff;
		if (win_hit) begin
			nxt_level  = win_lvl;
			nxt_vector = win_idx;
			nxt_vab    = win_addr;
		end
	end

	// Snapshot enables on entry to wait or stop
	always_comb begin
		nxt_lp_seen = low_power_mode;
		nxt_wake_en = wake_en_ff;
		if (low_power_mode && !lp_seen_ff)
			nxt_wake_en = src_en;
		nxt_wake = low_power_mode && lp_seen_ff && |(irq_req & wake_en_ff);
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_due_ff            <= 1'b0;
			irq_fast_ff           <= 1'b0;
			irq_level_ff          <= 2'h0;
			irq_vector_ff         <= '0;
			vector_address_bus_ff <= RST_PROG_ADDR;
			lp_seen_ff            <= 1'b0;
			wake_en_ff            <= '0;
			wake_request_ff       <= 1'b0;
		end else begin
			irq_due_ff            <= nxt_due;
			irq_fast_ff           <= nxt_fast;
			irq_level_ff          <= nxt_level;
			irq_vector_ff         <= nxt_vector;
			vector_address_bus_ff <= nxt_vab;
			lp_seen_ff            <= nxt_lp_seen;
			wake_en_ff            <= nxt_wake_en;
			wake_request_ff       <= nxt_wake;
		end
	end

endmodule : picp_interrupt_arbiter

// ### verification/picp_properties.sv
`timescale 1ns/1ps
module picp_properties
	import picp_pkg::*;
#(
	parameter int NSRC = 46,
	parameter int VW   = 7,
	parameter int AW   = 21
) (
	input wire logic            mclk,
	input wire logic            srst,
	input wire logic            reg_rd,
	input wire logic [15:0]     reg_rdata_ff,
	input wire logic [NSRC-1:0] irq_req,
	input wire logic [1:0]      core_status_mask,
	input wire logic            low_power_mode,
	input wire logic            irq_due_ff,
	input wire logic            irq_fast_ff,
	input wire logic [1:0]      irq_level_ff,
	input wire logic [VW-1:0]   irq_vector_ff,
	input wire logic [AW-1:0]   vector_address_bus_ff,
	input wire logic            wake_request_ff
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	function automatic logic [VW-1:0] first16(logic [15:0] r);
		first16 = '0;
		for (int i = 15; i >= 0; i--) begin
			if (r[i]) first16 = VW'(i);
		end
	endfunction : first16

	chk_fixed_due: assert property (|irq_req[15:0] |=> irq_due_ff && irq_level_ff == FIXED_LEVEL)
		else $error("fixed source not served at top level");
	chk_lowest_wins: assert property (|irq_req[15:0] |=> irq_vector_ff == first16($past(irq_req[15:0])))
		else $error("wrong winner among fixed sources");
	chk_fixed_not_fast: assert property (|irq_req[15:0] |=> !irq_fast_ff)
		else $error("top level winner flagged fast");
	chk_idle_no_due: assert property (irq_req == '0 |=> !irq_due_ff)
		else $error("due without any request");
	chk_mask_gate: assert property (irq_due_ff |-> irq_level_ff >= $past(core_status_mask))
		else $error("masked level reported due");
	chk_normal_vector: assert property (irq_due_ff && !irq_fast_ff |-> vector_address_bus_ff[6:0] == irq_vector_ff)
		else $error("vector low bits differ from source");
	chk_read_one_cycle: assert property (!reg_rd |=> reg_rdata_ff == 16'h0000)
		else $error("read data without a read");
	chk_wake_fixed: assert property ($past(low_power_mode) && low_power_mode && |irq_req[15:0] |=> wake_request_ff)
		else $error("no wake for pending request");
	chk_reset_address: assert property ($fell(srst) |-> vector_address_bus_ff == RST_PROG_ADDR && !irq_due_ff)
		else $error("reset address not driven");
endmodule : picp_properties

bind picp_interrupt_arbiter picp_properties #(.NSRC(NSRC), .VW(VW), .AW(AW)) u_picp_properties (
	.mclk(mclk), .srst(srst), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .irq_req(irq_req),
	.core_status_mask(core_status_mask), .low_power_mode(low_power_mode),
	.irq_due_ff(irq_due_ff), .irq_fast_ff(irq_fast_ff), .irq_level_ff(irq_level_ff),
	.irq_vector_ff(irq_vector_ff), .vector_address_bus_ff(vector_address_bus_ff),
	.wake_request_ff(wake_request_ff));

// ### verification/picp_core_model.sv
`timescale 1ns/1ps
module picp_core_model (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,
	// From controller
	input  wire logic        irq_due_ff,
	input  wire logic        irq_fast_ff,
	input  wire logic [20:0] vector_address_bus_ff,
	// Core state
	output      logic [20:0] taken_addr_ff,
	output      logic        fast_run_ff
);
	// Fetched word is never a subroutine jump, so a fast request runs fast
	always_ff @(posedge mclk) begin
		if (srst) begin
			taken_addr_ff <= 21'h000000;
			fast_run_ff   <= 1'b0;
		end else if (irq_due_ff) begin
			taken_addr_ff <= vector_address_bus_ff;
			fast_run_ff   <= irq_fast_ff;
		end
	end
endmodule : picp_core_model

// ### verification/picp_interrupt_arbiter_tb.sv
`timescale 1ns/1ps
module picp_interrupt_arbiter_tb;
	import picp_pkg::*;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic [4:0]  reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata_ff;
	logic [45:0] irq_req = '0;
	logic [1:0]  core_status_mask = 2'h0;
	logic        low_power_mode = 1'b0;
	logic        irq_due_ff;
	logic        irq_fast_ff;
	logic [1:0]  irq_level_ff;
	logic [6:0]  irq_vector_ff;
	logic [20:0] vector_address_bus;
	logic        wake_request_ff;
	logic [20:0] core_addr;
	logic        core_fast;
	logic [15:0] d;
	int          err_count = 0;
	int          checks_done = 0;
	int          cyc = 0;

	always #12.5 mclk = ~mclk;

	picp_interrupt_arbiter u_picp_interrupt_arbiter (.mclk(mclk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_ff(reg_rdata_ff), .irq_req(irq_req), .core_status_mask(core_status_mask),
		.low_power_mode(low_power_mode), .irq_due_ff(irq_due_ff), .irq_fast_ff(irq_fast_ff),
		.irq_level_ff(irq_level_ff), .irq_vector_ff(irq_vector_ff),
		.vector_address_bus_ff(vector_address_bus), .wake_request_ff(wake_request_ff));
	picp_core_model u_picp_core_model (.mclk(mclk), .srst(srst), .irq_due_ff(irq_due_ff),
		.irq_fast_ff(irq_fast_ff), .vector_address_bus_ff(vector_address_bus), .taken_addr_ff(core_addr),
		.fast_run_ff(core_fast));

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s exp %0h got %0h", n, e, s);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_ff;
	endtask : rd

	// Request pattern is seen one edge later, result settles after the next
	task automatic fire(input logic [45:0] v);
		@(posedge mclk);
		irq_req <= v;
		repeat (2) @(posedge mclk);
		#1;
	endtask : fire

	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic t_regs;
		rd(OFS_PRIORITY_LEVELS_A);
		chk("levels_a reset", 16'h0000, d);
		wr(OFS_PRIORITY_LEVELS_A, 16'hFFFF);
		wr(OFS_PRIORITY_LEVELS_B, 16'hFFFF);
		wr(5'h1F, 16'hFFFF);
		rd(OFS_PRIORITY_LEVELS_A);
		chk("levels_a", 16'hC3FF, d);
		rd(OFS_PRIORITY_LEVELS_B);
		chk("levels_b", 16'hFCFF, d);
		rd(5'h1F);
		chk("unmapped", 16'h0000, d);
		wr(OFS_PRIORITY_LEVELS_A, 16'h0000);
		wr(OFS_PRIORITY_LEVELS_B, 16'h0000);
	endtask : t_regs

	task automatic t_prio;
		fire(46'h208);
		chk("fixed level", 32'h3, irq_level_ff);
		chk("fixed vector", 32'h3, irq_vector_ff);
		rd(OFS_REQUEST_PENDING_A);
		chk("pending a", 32'h0208, d);
		wr(OFS_PRIORITY_LEVELS_E, 16'h0001);
		fire(46'h2000_0000_0000);
		chk("src45 level", 32'h0, irq_level_ff);
		chk("src45 address", 32'h2D, vector_address_bus);
		rd(OFS_REQUEST_PENDING_C);
		chk("pending c", 32'h2000, d);
		wr(OFS_PRIORITY_LEVELS_A, 16'hC100);
		fire(46'h21_0000);
		chk("top level", 32'h2, irq_level_ff);
		chk("top vector", 32'h15, irq_vector_ff);
		for (int m = 0; m < 4; m++) begin
			@(posedge mclk) core_status_mask <= 2'(m);
			fire(46'h1_0000);
			chk("mask due", 32'(m < 2), irq_due_ff);
		end
		wr(OFS_PRIORITY_LEVELS_A, 16'h0300);
		fire(46'h1_0000);
		chk("debug level", 32'h3, irq_level_ff);
		@(posedge mclk) core_status_mask <= 2'h0;
	endtask : t_prio

	task automatic t_fast;
		wr(OFS_VECTOR_TABLE_BASE, 16'hFFFF);
		wr(OFS_PRIORITY_LEVELS_A, 16'hC000);
		fire(46'h20_0000);
		chk("normal address", 32'h1FFF95, vector_address_bus);
		rd(OFS_REQUEST_PENDING_B);
		chk("pending b", 32'h0020, d);
		rd(OFS_VECTOR_TABLE_BASE);
		chk("base readback", 32'h3FFF, d);
		wr(OFS_FAST_MATCH_SLOT1, 16'h0015);
		wr(OFS_FAST_VECTOR_LOW_SLOT1, 16'h1234);
		wr(OFS_FAST_VECTOR_HIGH_SLOT1, 16'h001F);
		fire(46'h0);
		fire(46'h20_0000);
		chk("fast flag", 32'h1, irq_fast_ff);
		chk("core address", 32'h1F1234, core_addr);
		chk("core fast", 32'h1, core_fast);
		rd(OFS_CONTROLLER_CONTROL);
		chk("control status", 32'hE2A0, d);
		// Both slots match the same source; slot 0 takes precedence
		wr(OFS_FAST_MATCH_SLOT0, 16'h0015);
		wr(OFS_FAST_VECTOR_LOW_SLOT0, 16'hABCD);
		wr(OFS_FAST_VECTOR_HIGH_SLOT0, 16'hFFE2);
		fire(46'h20_0000);
		chk("slot0 address", 32'h02ABCD, vector_address_bus);
		rd(OFS_FAST_VECTOR_HIGH_SLOT0);
		chk("slot0 high", 32'h0002, d);
	endtask : t_fast

	task automatic t_wake;
		fire(46'h0);
		wr(OFS_PRIORITY_LEVELS_A, 16'h0100);
		@(posedge mclk) low_power_mode <= 1'b1;
		wr(OFS_PRIORITY_LEVELS_B, 16'hC000);
		fire(46'h40_0000);
		chk("late source wake", 32'h0, wake_request_ff);
		fire(46'h41_0000);
		chk("early source wake", 32'h1, wake_request_ff);
		fire(46'h40_0001);
		chk("fixed source wake", 32'h1, wake_request_ff);
		@(posedge mclk) low_power_mode <= 1'b0;
	endtask : t_wake

	// Reset in mid-run with requests withdrawn
	task automatic t_reset;
		@(posedge mclk);
		srst <= 1'b1;
		irq_req <= '0;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		#1;
		chk("mid reset address", 32'h0, vector_address_bus);
		chk("mid reset due", 32'h0, irq_due_ff);
		rd(OFS_VECTOR_TABLE_BASE);
		chk("base after reset", 32'h0, d);
		rd(OFS_PRIORITY_LEVELS_A);
		chk("levels_a after reset", 32'h0, d);
	endtask : t_reset

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			report_and_stop;
		end
	end

	initial begin
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		#1 chk("reset address", 32'h0, vector_address_bus);
		t_regs;
		t_prio;
		t_fast;
		t_wake;
		t_reset;
		report_and_stop;
	end
endmodule : picp_interrupt_arbiter_tb
